// file: rrx_pkg.sv
package rrx_pkg;
	// ----------------------------------------
	// Operation codes
	// ----------------------------------------
	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_OR_TO_MEMORY = 3'h1,
		OP_SUBROUTINE_RETURN = 3'h2,
		OP_RETURN_IMMEDIATE = 3'h3,
		OP_INTERRUPT_RETURN = 3'h4,
		OP_ROTATE_LEFT = 3'h5,
		OP_ROTATE_LEFT_TO_REG = 3'h6,
		OP_ROTATE_LEFT_CARRY = 3'h7
	} rrx_op_t;
	// Carry-to-register form uses a separate strobe bit
	localparam int DATA_W = 8;
	localparam int PC_W = 13;
	localparam int MSB = 7;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [12:0] PC_RESET = 13'h0000;
	localparam logic [7:0] WORK_RESET = 8'h00;
endpackage

// file: rrx_core.sv
`timescale 1ns/1ps
module rrx_core #(
	parameter int PC_WIDTH = rrx_pkg::PC_W
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic op_valid_i,
	input wire rrx_pkg::rrx_op_t op_code_i,
	input wire logic carry_to_reg_i,
	input wire logic [7:0] mem_rd_data_i,
	input wire logic [7:0] imm_data_i,
	input wire logic [PC_WIDTH-1:0] stack_top_i,
	input wire logic irq_pending_i,
	input wire logic [7:0] work_register_i,
	input wire logic carry_i,
	input wire logic zero_i,
	input wire logic global_interrupt_enable_i,
	output logic [7:0] mem_wr_data_o,
	output logic mem_wr_en_o,
	output logic [7:0] work_register_o,
	output logic carry_o,
	output logic zero_o,
	output logic global_interrupt_enable_o,
	output logic stack_pop_o,
	output logic pc_load_o,
	output logic [PC_WIDTH-1:0] pc_value_o,
	output logic irq_take_o
);
	// ----------------------------------------
	// Elaboration check
	// ----------------------------------------
	if (PC_WIDTH < 1 || PC_WIDTH > 16) begin : g_bad_pc
		$error("PC_WIDTH out of range");
	end

	typedef struct packed {
		logic [7:0] mem_wr_data;
		logic mem_wr_en;
		logic [7:0] work;
		logic carry;
		logic zero;
		logic gie;
		logic pop;
		logic pc_load;
		logic [PC_WIDTH-1:0] pc_value;
		logic irq_take;
	} rrx_state_t;

	rrx_state_t st_ff;
	rrx_state_t nxt_st;
	// Kept apart from the state struct: it runs on the raw reset, the struct on its copy
	logic [1:0] rst_sync_ff;
	logic rst_n;

	function automatic logic [7:0] rot_left(input logic [7:0] v, input logic in_bit);
		rot_left = {v[rrx_pkg::MSB-1:0], in_bit};
	endfunction

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_sync_ff <= 2'h0;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_ff[1];

	// ----------------------------------------
	// Execute
	// ----------------------------------------
	always_comb begin
		nxt_st = st_ff;
		nxt_st.mem_wr_en = 1'b0;
		nxt_st.pop = 1'b0;
		nxt_st.pc_load = 1'b0;
		nxt_st.irq_take = 1'b0;
		// Flags default to the carry_i, zero_i and global_interrupt_enable_i inputs, so untouched ops pass them on
		nxt_st.work = work_register_i;
		nxt_st.carry = carry_i;
		nxt_st.zero = zero_i;
		nxt_st.gie = global_interrupt_enable_i;
		nxt_st.mem_wr_data = mem_rd_data_i;
		nxt_st.pc_value = stack_top_i;
		if (op_valid_i) begin
			case (op_code_i)
				rrx_pkg::OP_OR_TO_MEMORY: begin
					nxt_st.mem_wr_data = work_register_i | mem_rd_data_i;
					nxt_st.mem_wr_en = 1'b1;
					nxt_st.zero = ((work_register_i | mem_rd_data_i) == rrx_pkg::BYTE_ZERO);
				end
				rrx_pkg::OP_SUBROUTINE_RETURN: begin
					nxt_st.pop = 1'b1;
					nxt_st.pc_load = 1'b1;
				end
				rrx_pkg::OP_RETURN_IMMEDIATE: begin
					nxt_st.pop = 1'b1;
					nxt_st.pc_load = 1'b1;
					nxt_st.work = imm_data_i;
				end
				rrx_pkg::OP_INTERRUPT_RETURN: begin
					nxt_st.pop = 1'b1;
					nxt_st.pc_load = 1'b1;
					nxt_st.gie = 1'b1;
					nxt_st.irq_take = irq_pending_i;
				end
				rrx_pkg::OP_ROTATE_LEFT: begin
					nxt_st.mem_wr_data = rot_left(mem_rd_data_i, mem_rd_data_i[rrx_pkg::MSB]);
					nxt_st.mem_wr_en = 1'b1;
				end
				rrx_pkg::OP_ROTATE_LEFT_TO_REG: begin
					nxt_st.work = rot_left(mem_rd_data_i, mem_rd_data_i[rrx_pkg::MSB]);
				end
				rrx_pkg::OP_ROTATE_LEFT_CARRY: begin
					nxt_st.carry = mem_rd_data_i[rrx_pkg::MSB];
					if (carry_to_reg_i) begin
						nxt_st.work = rot_left(mem_rd_data_i, carry_i);
					end else begin
						nxt_st.mem_wr_data = rot_left(mem_rd_data_i, carry_i);
						nxt_st.mem_wr_en = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			st_ff.mem_wr_data <= rrx_pkg::BYTE_ZERO;
			st_ff.mem_wr_en <= 1'b0;
			st_ff.work <= rrx_pkg::WORK_RESET;
			st_ff.carry <= 1'b0;
			st_ff.zero <= 1'b0;
			st_ff.gie <= 1'b0;
			st_ff.pop <= 1'b0;
			st_ff.pc_load <= 1'b0;
			st_ff.pc_value <= '0;
			st_ff.irq_take <= 1'b0;
		end else begin
			st_ff.mem_wr_data <= nxt_st.mem_wr_data;
			st_ff.mem_wr_en <= nxt_st.mem_wr_en;
			st_ff.work <= nxt_st.work;
			st_ff.carry <= nxt_st.carry;
			st_ff.zero <= nxt_st.zero;
			st_ff.gie <= nxt_st.gie;
			st_ff.pop <= nxt_st.pop;
			st_ff.pc_load <= nxt_st.pc_load;
			st_ff.pc_value <= nxt_st.pc_value;
			st_ff.irq_take <= nxt_st.irq_take;
		end
	end

	assign mem_wr_data_o = st_ff.mem_wr_data;
	assign mem_wr_en_o = st_ff.mem_wr_en;
	assign work_register_o = st_ff.work;
	assign carry_o = st_ff.carry;
	assign zero_o = st_ff.zero;
	assign global_interrupt_enable_o = st_ff.gie;
	assign stack_pop_o = st_ff.pop;
	assign pc_load_o = st_ff.pc_load;
	assign pc_value_o = st_ff.pc_value;
	assign irq_take_o = st_ff.irq_take;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n);

	or_write_a: assert property (op_valid_i && op_code_i == rrx_pkg::OP_OR_TO_MEMORY |=>
		mem_wr_en_o && mem_wr_data_o == ($past(work_register_i) | $past(mem_rd_data_i)))
		else $error("OR write-back wrong");
	ret_pop_a: assert property (op_valid_i && op_code_i == rrx_pkg::OP_SUBROUTINE_RETURN |=>
		stack_pop_o && pc_load_o && pc_value_o == $past(stack_top_i) && carry_o == $past(carry_i))
		else $error("return pop wrong");
	ret_imm_a: assert property (op_valid_i && op_code_i == rrx_pkg::OP_RETURN_IMMEDIATE |=>
		pc_load_o && work_register_o == $past(imm_data_i) && zero_o == $past(zero_i))
		else $error("return immediate wrong");
	interrupt_return_op_gie_a: assert property (op_valid_i && op_code_i == rrx_pkg::OP_INTERRUPT_RETURN |=>
		pc_load_o && global_interrupt_enable_o)
		else $error("interrupt return wrong");
	interrupt_return_op_pend_a: assert property (op_valid_i && op_code_i == rrx_pkg::OP_INTERRUPT_RETURN
		&& irq_pending_i |=> irq_take_o)
		else $error("pending interrupt not taken");
	rot_mem_a: assert property (op_valid_i && op_code_i == rrx_pkg::OP_ROTATE_LEFT |=>
		mem_wr_en_o && mem_wr_data_o == {$past(mem_rd_data_i[6:0]), $past(mem_rd_data_i[7])})
		else $error("rotate left wrong");
	rot_reg_a: assert property (op_valid_i && op_code_i == rrx_pkg::OP_ROTATE_LEFT_TO_REG |=>
		!mem_wr_en_o && work_register_o == {$past(mem_rd_data_i[6:0]), $past(mem_rd_data_i[7])})
		else $error("rotate to register wrong");
	rlc_mem_a: assert property (op_valid_i && op_code_i == rrx_pkg::OP_ROTATE_LEFT_CARRY
		&& !carry_to_reg_i |=> mem_wr_en_o && carry_o == $past(mem_rd_data_i[7])
		&& mem_wr_data_o[0] == $past(carry_i))
		else $error("rotate through carry wrong");
	rlc_reg_a: assert property (op_valid_i && op_code_i == rrx_pkg::OP_ROTATE_LEFT_CARRY
		&& carry_to_reg_i |=> !mem_wr_en_o
		&& {carry_o, work_register_o} == {$past(mem_rd_data_i), $past(carry_i)})
		else $error("rotate carry to register wrong");
	zero_flag_a: assert property (mem_wr_en_o && $past(op_code_i) == rrx_pkg::OP_OR_TO_MEMORY
		&& $past(op_valid_i) |-> zero_o == (mem_wr_data_o == rrx_pkg::BYTE_ZERO))
		else $error("zero flag wrong");

	or_zero_c: cover property (op_valid_i && op_code_i == rrx_pkg::OP_OR_TO_MEMORY ##1 zero_o);
	interrupt_return_op_irq_c: cover property (irq_take_o);
	rlc_reg_c: cover property (op_valid_i && carry_to_reg_i
		&& op_code_i == rrx_pkg::OP_ROTATE_LEFT_CARRY);
endmodule

// file: test_return_and_rotate_instructions.sv
`timescale 1ns/1ps
module test_return_and_rotate_instructions;
	typedef struct packed {
		logic wr_en;
		logic [7:0] wr_data;
		logic [7:0] work;
		logic carry;
		logic zero;
		logic gie;
		logic pop;
		logic load;
		logic [12:0] pc;
		logic take;
	} rrx_exp_t;
	localparam int PCW = 13;
	logic ref_clk_i = 0, rst_n_i = 0, op_valid_i = 0, carry_to_reg_i = 0, irq_pending_i = 0;
	logic carry_i = 0, zero_i = 0, global_interrupt_enable_i = 0;
	logic [7:0] mem_rd_data_i = 8'h00, imm_data_i = 8'h00, work_register_i = 8'h00;
	logic [PCW-1:0] stack_top_i = 13'h0000;
	rrx_pkg::rrx_op_t op_code_i = rrx_pkg::OP_NONE;
	logic [7:0] mem_wr_data_o, work_register_o;
	logic mem_wr_en_o, carry_o, zero_o, global_interrupt_enable_o, stack_pop_o, pc_load_o;
	logic irq_take_o;
	logic [PCW-1:0] pc_value_o;
	rrx_exp_t exp_q[$];
	int num_errors = 0, n_compared = 0;

	rrx_core #(.PC_WIDTH(PCW)) DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.op_valid_i(op_valid_i), .op_code_i(op_code_i), .carry_to_reg_i(carry_to_reg_i),
		.mem_rd_data_i(mem_rd_data_i), .imm_data_i(imm_data_i), .stack_top_i(stack_top_i),
		.irq_pending_i(irq_pending_i), .work_register_i(work_register_i), .carry_i(carry_i),
		.zero_i(zero_i), .global_interrupt_enable_i(global_interrupt_enable_i),
		.mem_wr_data_o(mem_wr_data_o), .mem_wr_en_o(mem_wr_en_o),
		.work_register_o(work_register_o), .carry_o(carry_o), .zero_o(zero_o),
		.global_interrupt_enable_o(global_interrupt_enable_o), .stack_pop_o(stack_pop_o),
		.pc_load_o(pc_load_o), .pc_value_o(pc_value_o), .irq_take_o(irq_take_o));

	initial begin
		forever #12.5 ref_clk_i = ~ref_clk_i;
	end

	task automatic check(input string what, input logic [12:0] seen, input logic [12:0] expv);
		n_compared++;
		if (seen !== expv) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, expv, seen);
		end
	endtask

	task automatic final_report;
		if (num_errors == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Driver: random operands, expected note
	// ----------------------------------------
	task automatic step(input logic v, input logic [2:0] op, input logic ctr, input logic zd);
		rrx_exp_t e;
		logic [7:0] rot;
		op_valid_i = v;
		op_code_i = rrx_pkg::rrx_op_t'(op);
		carry_to_reg_i = ctr;
		mem_rd_data_i = zd ? 8'h00 : 8'($urandom);
		work_register_i = zd ? 8'h00 : 8'($urandom);
		imm_data_i = 8'($urandom);
		stack_top_i = PCW'($urandom);
		{irq_pending_i, carry_i, zero_i, global_interrupt_enable_i} = 4'($urandom);
		e = '0;
		e.work = work_register_i;
		e.carry = carry_i;
		e.zero = zero_i;
		e.gie = global_interrupt_enable_i;
		rot = {mem_rd_data_i[6:0], mem_rd_data_i[7]};
		if (v) begin
			if (op inside {3'h2, 3'h3, 3'h4}) begin
				{e.pop, e.load, e.pc} = {2'b11, stack_top_i};
			end
			case (op_code_i)
				rrx_pkg::OP_OR_TO_MEMORY: begin
					{e.wr_en, e.wr_data} = {1'b1, work_register_i | mem_rd_data_i};
					e.zero = (e.wr_data == 8'h00);
				end
				rrx_pkg::OP_RETURN_IMMEDIATE: e.work = imm_data_i;
				rrx_pkg::OP_INTERRUPT_RETURN: {e.gie, e.take} = {1'b1, irq_pending_i};
				rrx_pkg::OP_ROTATE_LEFT: {e.wr_en, e.wr_data} = {1'b1, rot};
				rrx_pkg::OP_ROTATE_LEFT_TO_REG: e.work = rot;
				rrx_pkg::OP_ROTATE_LEFT_CARRY: begin
					rot = {mem_rd_data_i[6:0], carry_i};
					e.carry = mem_rd_data_i[7];
					if (ctr) e.work = rot;
					else {e.wr_en, e.wr_data} = {1'b1, rot};
				end
				default: ;
			endcase
		end
		exp_q.push_back(e);
		@(negedge ref_clk_i);
	endtask

	// ----------------------------------------
	// Monitor: oldest note against outputs
	// ----------------------------------------
	initial begin
		rrx_exp_t e;
		forever begin
			@(posedge ref_clk_i);
			#1;
			if (exp_q.size() > 0) begin
				e = exp_q.pop_front();
				check("mem_wr_en_o", 13'(mem_wr_en_o), 13'(e.wr_en));
				if (e.wr_en) check("mem_wr_data_o", 13'(mem_wr_data_o), 13'(e.wr_data));
				check("work_register_o", 13'(work_register_o), 13'(e.work));
				check("carry_o", 13'(carry_o), 13'(e.carry));
				check("zero_o", 13'(zero_o), 13'(e.zero));
				check("gie_o", 13'(global_interrupt_enable_o), 13'(e.gie));
				check("stack_pop_o", 13'(stack_pop_o), 13'(e.pop));
				check("pc_load_o", 13'(pc_load_o), 13'(e.load));
				if (e.load) check("pc_value_o", pc_value_o, e.pc);
				check("irq_take_o", 13'(irq_take_o), 13'(e.take));
			end
		end
	end

	initial begin
		#50000;
		num_errors++;
		final_report();
	end

	initial begin
		void'($urandom(83519));
		repeat (5) @(negedge ref_clk_i);
		rst_n_i = 1;
		repeat (3) @(negedge ref_clk_i);
		// Every code with both carry targets, first with all-zero data
		for (int i = 0; i < 32; i++) step(1'b1, i[2:0], i[3], i < 16);
		repeat (400) step($urandom_range(0, 3) != 0, 3'($urandom), 1'($urandom), 1'b0);
		op_valid_i = 0;
		repeat (3) @(negedge ref_clk_i);
		final_report();
	end
endmodule
